// File: common/cpr_link_if.sv
`timescale 1ns/1ps
interface cpr_link_if;
    logic reset_b;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [cpr_pkg::BA_W-1:0] ba;
    logic [cpr_pkg::ADDR_W-1:0] addr;
    logic [cpr_pkg::DQ_W-1:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic [cpr_pkg::DQ_W-1:0] dram_dq_o;
    logic dram_dq_oe;
    logic [cpr_pkg::DQ_W-1:0] dq;

    // The data wire is resolved here; an undriven bus reads as zero.
    assign dq = dram_dq_oe ? dram_dq_o : (ctl_dq_oe ? ctl_dq_o : 8'h00);

    modport ctrl (
        output reset_b, cs_n, ras_n, cas_n, we_n, ba, addr, ctl_dq_o, ctl_dq_oe,
        input dq
    );
    modport dram (
        input reset_b, cs_n, ras_n, cas_n, we_n, ba, addr, dq,
        output dram_dq_o, dram_dq_oe
    );
endinterface

// File: common/cpr_pkg.sv
// How it works
// R1 - Controller sets mode bit A2 in mode_register_three.
// R2 - Controller precharges all banks before enabling.
// R3 - Reads come from the pattern register while enabled.
// R4 - Controller issues only reads until mode cleared.
// R5 - Device reset pin still works in pattern mode.
// R6 - Read with autoprecharge acts as plain read.
// R7 - Mode off: location ignored, array used normally.
// R8 - Pattern on lane 0, upper lanes copy or zero.
// R9 - Controller drives column bits 1:0 as zero.
// R10 - Full bursts use address bit 2 zero, order 0-7.
// R11 - Chopped half chosen by address bit 2.
// R12 - On-the-fly chop taken from address bit 12.
// R13 - Other column and bank bits are ignored.
// R14 - Pattern reads use normal read latency.
// R15 - Controller waits for DLL lock before reading.
// R16 - Beat 0 is LSB, beat 7 is MSB.
// R17 - Location 00 returns alternating 0,1 pattern.
// R18 - Controller selects only location 00.
// R19 - Mode register three selected by bank 011.
// R20 - Reserved bits and BA2 written as zero.
package cpr_pkg;
    // ==========================================
    // Timing
    localparam int CLK_NS = 25;
    localparam int T_RP_NS = 15;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
        (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int MRD_CYC = 4;
    localparam int MOD_CYC = 12;
    localparam int READ_LAT = 5;
    // ==========================================
    // Widths
    localparam int ADDR_W = 16;
    localparam int BA_W = 3;
    localparam int DQ_W = 8;
    // ==========================================
    // Commands as {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR3 = 3'h3;
    // ==========================================
    // Field positions
    localparam int PAT_EN_BIT = 2;
    localparam int LOC_LSB = 0;
    localparam int BL_LSB = 0;
    localparam int HALF_BIT = 2;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    // ==========================================
    // Field values and reset values
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [1:0] LOC_CAL = 2'h0;
    localparam logic [7:0] PAT_CAL = 8'haa;
    localparam logic [7:0] PAT_RFU = 8'h00;
    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;
endpackage

// File: src/cpr_ctrl.sv
`timescale 1ns/1ps
module cpr_ctrl #(
    parameter int READ_LAT = cpr_pkg::READ_LAT,
    parameter int RP_CYC = cpr_pkg::RP_CYC,
    parameter int MRD_CYC = cpr_pkg::MRD_CYC,
    parameter int MOD_CYC = cpr_pkg::MOD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // User request
    input wire logic start,
    input wire logic use_chop,
    input wire logic upper_half,
    input wire logic dll_locked,
    // User result
    output logic busy,
    output logic done,
    output logic pass,
    output logic [7:0] pattern,
    // Link to the memory
    cpr_link_if.ctrl link
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_PRE, ST_MR0, ST_MR3, ST_READ, ST_CAP, ST_CLR, ST_FIN
    } cpr_state_t;

    cpr_state_t state;
    logic [7:0] wait_cnt;
    logic [2:0] bidx;
    logic [3:0] left;
    logic chop;
    logic half;

    // Command encodings are driven from flops so the memory samples clean levels.
    task automatic issue(input logic [2:0] rcw, input logic [2:0] ba,
                         input logic [15:0] addr);
        link.cs_n <= 1'b0;
        {link.ras_n, link.cas_n, link.we_n} <= rcw;
        link.ba <= ba;
        link.addr <= addr;
    endtask

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link.reset_b <= 1'b0;
        end else begin
            link.reset_b <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link.ctl_dq_o <= 8'h00;
            link.ctl_dq_oe <= 1'b0;
        end else begin
            link.ctl_dq_o <= 8'h00;
            link.ctl_dq_oe <= 1'b0;
        end
    end

    // ==========================================
    // Sequencer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            wait_cnt <= 8'h00;
            bidx <= 3'h0;
            left <= 4'h0;
            chop <= 1'b0;
            half <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            pass <= 1'b0;
            pattern <= 8'h00;
            link.cs_n <= 1'b1;
            {link.ras_n, link.cas_n, link.we_n} <= cpr_pkg::CMD_NOP;
            link.ba <= 3'h0;
            link.addr <= 16'h0000;
        end else begin
            done <= 1'b0;
            link.cs_n <= 1'b1;
            {link.ras_n, link.cas_n, link.we_n} <= cpr_pkg::CMD_NOP;
            if (wait_cnt != 8'h00) begin
                wait_cnt <= wait_cnt - 8'h01;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (start && dll_locked) begin // [R15]
                            busy <= 1'b1;
                            chop <= use_chop;
                            half <= use_chop & upper_half;
                            pattern <= 8'h00;
                            issue(cpr_pkg::CMD_PRE, 3'h0, 16'h0400); // [R2]
                            wait_cnt <= 8'(RP_CYC);
                            state <= ST_PRE;
                        end
                    end
                    ST_PRE: begin
                        issue(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR0, {14'h0000, cpr_pkg::BL_OTF});
                        wait_cnt <= 8'(MRD_CYC);
                        state <= ST_MR0;
                    end
                    ST_MR0: begin
                        // Only bit 2 is set; location 00, reserved bits and BA2 stay zero.
                        issue(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR3, 16'h0004); // [R1] [R18] [R19] [R20]
                        wait_cnt <= 8'(MOD_CYC);
                        state <= ST_MR3;
                    end
                    ST_MR3: begin
                        // Bits 1:0 zero, bit 2 picks the half, bit 12 high asks for eight beats.
                        issue(cpr_pkg::CMD_RD, 3'h0, {3'h0, !chop, 9'h000, half, 2'h0}); // [R9] [R10]
                        wait_cnt <= 8'(READ_LAT);
                        bidx <= {half, 2'h0};
                        left <= chop ? cpr_pkg::BEATS_CHOP : cpr_pkg::BEATS_FULL;
                        state <= ST_CAP;
                    end
                    ST_CAP: begin
                        pattern[bidx] <= link.dq[0];
                        bidx <= bidx + 3'h1;
                        left <= left - 4'h1;
                        if (left == 4'h1) begin
                            state <= ST_CLR;
                        end
                    end
                    ST_CLR: begin
                        // Nothing but reads went out while the mode was on.
                        issue(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR3, 16'h0000); // [R4]
                        wait_cnt <= 8'(MOD_CYC);
                        state <= ST_FIN;
                    end
                    ST_FIN: begin
                        pass <= ((pattern ^ cpr_pkg::PAT_CAL) &
                            (chop ? (half ? 8'hf0 : 8'h0f) : 8'hff)) == 8'h00;
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= ST_IDLE;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// File: src/cpr_dram.sv
`timescale 1ns/1ps
module cpr_dram #(
    parameter int READ_LAT = cpr_pkg::READ_LAT,
    parameter int ARR_AW = 6,
    parameter bit LANE_COPY = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link to the controller
    cpr_link_if.dram link,
    // Status
    output logic pattern_mode,
    output logic [1:0] pattern_loc,
    output logic illegal_cmd,
    output logic ap_done
);
    localparam int PD = READ_LAT - 1;
    localparam int CW = ARR_AW - 3;
    localparam int EW = 8 + CW;

    // ==========================================
    // Command decode
    function automatic logic is_cmd(input logic cs_n, input logic [2:0] rcw,
                                    input logic [2:0] code);
        return !cs_n && (rcw == code);
    endfunction

    logic run_b;
    logic [2:0] rcw;
    logic mrs_hit;
    logic rd_hit;
    logic wr_hit;
    logic nop_hit;

    // The pin reset is folded in with the local one so it acts in every mode.
    assign run_b = rst_b & link.reset_b; // [R5]
    assign rcw = {link.ras_n, link.cas_n, link.we_n};
    assign mrs_hit = is_cmd(link.cs_n, rcw, cpr_pkg::CMD_MRS);
    assign rd_hit = is_cmd(link.cs_n, rcw, cpr_pkg::CMD_RD);
    assign wr_hit = is_cmd(link.cs_n, rcw, cpr_pkg::CMD_WR);
    assign nop_hit = is_cmd(link.cs_n, rcw, cpr_pkg::CMD_NOP);

    // ==========================================
    // Mode registers
    logic [1:0] bl_mode;

    always_ff @(posedge clk) begin
        if (!run_b) begin
            pattern_mode <= 1'b0;
            pattern_loc <= cpr_pkg::LOC_CAL;
            bl_mode <= cpr_pkg::BL_FIXED8;
        end else if (mrs_hit && link.ba == cpr_pkg::BA_MR3) begin
            pattern_mode <= link.addr[cpr_pkg::PAT_EN_BIT];
            pattern_loc <= link.addr[cpr_pkg::LOC_LSB +: 2];
        end else if (mrs_hit && link.ba == cpr_pkg::BA_MR0) begin
            bl_mode <= link.addr[cpr_pkg::BL_LSB +: 2];
        end
    end

    // In pattern mode, anything but a read, a mode set or a no-op is flagged, then dropped.
    always_ff @(posedge clk) begin
        if (!run_b) begin
            illegal_cmd <= 1'b0;
        end else begin
            illegal_cmd <= pattern_mode && !link.cs_n && !rd_hit && !mrs_hit && !nop_hit;
        end
    end

    // ==========================================
    // Command capture
    logic chop;
    logic [2:0] start;
    logic [EW-1:0] entry;

    always_comb begin
        case (bl_mode)
            cpr_pkg::BL_OTF: chop = !link.addr[cpr_pkg::BC_BIT]; // [R12]
            cpr_pkg::BL_FIXED4: chop = 1'b1;
            default: chop = 1'b0;
        endcase
        // Low column bits never steer the order; only the chopped half does.
        start = chop ? {link.addr[cpr_pkg::HALF_BIT], 2'b00} : 3'h0; // [R11] [R10] [R13]
        entry = {
            rd_hit | (wr_hit & !pattern_mode),
            wr_hit & !pattern_mode,
            pattern_mode, // [R3] [R7]
            link.addr[cpr_pkg::AP_BIT] & !pattern_mode, // [R6]
            chop,
            start,
            link.addr[ARR_AW-1:3]
        };
    end

    // ==========================================
    // Latency pipe, shared by array and pattern reads
    logic [EW-1:0] pipe [PD];

    generate
        for (genvar k = 0; k < PD; k++) begin : g_pipe
            // The head stage is split off so no stage ever names a stage below zero.
            if (k == 0) begin : g_head
                always_ff @(posedge clk) begin
                    if (!run_b) begin
                        pipe[k] <= '0;
                    end else begin
                        pipe[k] <= entry; // [R14]
                    end
                end
            end else begin : g_tail
                always_ff @(posedge clk) begin
                    if (!run_b) begin
                        pipe[k] <= '0;
                    end else begin
                        pipe[k] <= pipe[k-1];
                    end
                end
            end
        end
    endgenerate

    logic head_v;
    logic head_wr;
    logic head_pat;
    logic head_ap;
    logic head_chop;
    logic [2:0] head_start;
    logic [CW-1:0] head_col;

    assign {head_v, head_wr, head_pat, head_ap, head_chop, head_start, head_col} = pipe[PD-1];

    // ==========================================
    // Burst engine
    logic [3:0] left;
    logic [2:0] idx;
    logic cur_wr;
    logic cur_pat;
    logic cur_ap;
    logic [CW-1:0] cur_col;

    always_ff @(posedge clk) begin
        if (!run_b) begin
            left <= 4'h0;
            idx <= 3'h0;
            cur_wr <= 1'b0;
            cur_pat <= 1'b0;
            cur_ap <= 1'b0;
            cur_col <= '0;
        end else if (head_v) begin
            left <= (head_chop ? cpr_pkg::BEATS_CHOP : cpr_pkg::BEATS_FULL) - 4'h1;
            idx <= head_start + 3'h1;
            cur_wr <= head_wr;
            cur_pat <= head_pat;
            cur_ap <= head_ap;
            cur_col <= head_col;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
            idx <= idx + 3'h1;
        end
    end

    logic go;
    logic b_wr;
    logic b_pat;
    logic [2:0] b_idx;
    logic [CW-1:0] b_col;
    logic [7:0] pat_byte;
    logic pat_bit;

    always_comb begin
        go = head_v || (left != 4'h0);
        b_wr = head_v ? head_wr : cur_wr;
        b_pat = head_v ? head_pat : cur_pat;
        b_idx = head_v ? head_start : idx;
        b_col = head_v ? head_col : cur_col;
        case (pattern_loc)
            cpr_pkg::LOC_CAL: pat_byte = cpr_pkg::PAT_CAL; // [R17]
            default: pat_byte = cpr_pkg::PAT_RFU;
        endcase
        pat_bit = pat_byte[b_idx]; // [R16]
    end

    // ==========================================
    // Array and data pins
    logic [7:0] mem [2**ARR_AW];

    always_ff @(posedge clk) begin
        if (run_b && go && b_wr) begin
            mem[{b_col, b_idx}] <= link.dq;
        end
    end

    always_ff @(posedge clk) begin
        if (!run_b) begin
            link.dram_dq_oe <= 1'b0;
            link.dram_dq_o <= 8'h00;
        end else begin
            link.dram_dq_oe <= go && !b_wr;
            if (b_pat) begin
                link.dram_dq_o <= {(LANE_COPY ? {7{pat_bit}} : 7'h00), pat_bit}; // [R8]
            end else begin
                link.dram_dq_o <= mem[{b_col, b_idx}];
            end
        end
    end

    // The precharge itself is not modelled; the pulse marks when it would start.
    always_ff @(posedge clk) begin
        if (!run_b) begin
            ap_done <= 1'b0;
        end else begin
            ap_done <= !head_v && (left == 4'h1) && cur_ap; // [R6]
        end
    end
endmodule

// File: verification/cpr_link_sva.sv
`timescale 1ns/1ps
// ==========
// Checks on the link between the controller and the memory.
module cpr_link_sva #(
    parameter int READ_LAT = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link
    input wire logic reset_b,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [cpr_pkg::BA_W-1:0] ba,
    input wire logic [cpr_pkg::ADDR_W-1:0] addr,
    input wire logic [cpr_pkg::DQ_W-1:0] dram_dq_o,
    input wire logic dram_dq_oe
);
    localparam int LAT_M1 = READ_LAT - 1;
    logic [2:0] cmd;
    logic rd;
    logic mrs;
    logic mode_on;
    logic pre_seen;
    logic [2:0] base;
    logic [2:0] beat;
    assign cmd = {ras_n, cas_n, we_n};
    assign rd = !cs_n && cmd == cpr_pkg::CMD_RD;
    assign mrs = !cs_n && cmd == cpr_pkg::CMD_MRS;
    // The mode is tracked here from the commands alone, so a slip in either end shows.
    always_ff @(posedge clk) begin
        if (!rst_b || !reset_b) begin
            mode_on <= 1'h0;
        end else if (mrs && ba == cpr_pkg::BA_MR3) begin
            mode_on <= addr[cpr_pkg::PAT_EN_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_seen <= 1'h0;
        end else if (!cs_n && cmd == cpr_pkg::CMD_PRE && addr[cpr_pkg::AP_BIT]) begin
            pre_seen <= 1'h1;
        end else if (rd) begin
            pre_seen <= 1'h0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            base <= 3'h0;
        end else if (rd) begin
            base <= {addr[cpr_pkg::HALF_BIT], 2'h0};
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b || !dram_dq_oe) begin
            beat <= 3'h0;
        end else begin
            beat <= beat + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_lane_copy;
        dram_dq_oe && mode_on |->
            dram_dq_o[7:1] == {7{dram_dq_o[0]}} || dram_dq_o[7:1] == 7'h00;
    endproperty
    a_lane_copy: assert property (p_lane_copy) else $error("upper lanes wrong");
    property p_pattern_data;
        dram_dq_oe && mode_on |-> dram_dq_o[0] == cpr_pkg::PAT_CAL[base + beat];
    endproperty
    a_pattern_data: assert property (p_pattern_data) else $error("pattern bit wrong");
    property p_mr3_fields;
        mrs && ba[1:0] == 2'h3 |-> !ba[2] && addr[15:3] == 13'h0;
    endproperty
    a_mr3_fields: assert property (p_mr3_fields) else $error("mode write bits wrong");
    property p_read_col;
        rd && mode_on |-> addr[1:0] == 2'h0 && (!addr[cpr_pkg::BC_BIT] || !addr[2]);
    endproperty
    a_read_col: assert property (p_read_col) else $error("read column wrong");
    property p_mode_cmds;
        mode_on && !cs_n |->
            cmd == cpr_pkg::CMD_RD || cmd == cpr_pkg::CMD_MRS || cmd == cpr_pkg::CMD_NOP;
    endproperty
    a_mode_cmds: assert property (p_mode_cmds) else $error("command in pattern mode");
    property p_mr3_pre;
        mrs && ba == cpr_pkg::BA_MR3 && addr[2] |-> pre_seen;
    endproperty
    a_mr3_pre: assert property (p_mr3_pre) else $error("mode entry without precharge");
    property p_burst8;
        rd && mode_on && addr[cpr_pkg::BC_BIT] |->
            ##LAT_M1 !dram_dq_oe ##1 dram_dq_oe [*8] ##1 !dram_dq_oe;
    endproperty
    a_burst8: assert property (p_burst8) else $error("full burst wrong");
    property p_burst4;
        rd && mode_on && !addr[cpr_pkg::BC_BIT] |->
            ##LAT_M1 !dram_dq_oe ##1 dram_dq_oe [*4] ##1 !dram_dq_oe;
    endproperty
    a_burst4: assert property (p_burst4) else $error("chopped burst wrong");
    c_burst8: cover property (rd && mode_on && addr[cpr_pkg::BC_BIT]);
    c_burst4: cover property (rd && mode_on && !addr[cpr_pkg::BC_BIT]);
    c_enter: cover property (mrs && ba == cpr_pkg::BA_MR3 && addr[2]);
endmodule

// File: verification/dram_calibration_pattern_read_test.sv
`timescale 1ns/1ps
// ==========
// Bench: one pair of ends joined, and one memory end driven directly.
module dram_calibration_pattern_read_test;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic start = 1'h0;
    logic use_chop = 1'h0;
    logic upper_half = 1'h0;
    logic dll_locked = 1'h1;
    logic busy, done, pass, b_mode, b_ill, b_ap, ap_seen, ill_seen;
    logic [7:0] pattern;
    logic [1:0] b_loc;
    logic [63:0] arr = 64'h1716151413121110;
    logic [1:0] tb_bl [4] = '{cpr_pkg::BL_OTF, cpr_pkg::BL_OTF, cpr_pkg::BL_OTF,
        cpr_pkg::BL_FIXED4};
    logic [15:0] tb_a [4] = '{16'h1000, 16'h0000, 16'h0004, 16'h1004};
    int tb_n [4] = '{8, 4, 4, 4};
    int tb_f [4] = '{0, 0, 4, 4};
    int err_count = 0;
    int n_compared = 0;
    cpr_link_if link_a();
    cpr_link_if link_b();
    always #12.5 clk = ~clk;
    cpr_ctrl cpr_ctrl_inst (.clk(clk), .rst_b(rst_b), .start(start), .use_chop(use_chop),
        .upper_half(upper_half), .dll_locked(dll_locked), .busy(busy), .done(done),
        .pass(pass), .pattern(pattern), .link(link_a.ctrl));
    cpr_dram cpr_dram_inst (.clk(clk), .rst_b(rst_b), .link(link_a.dram), .pattern_mode(),
        .pattern_loc(), .illegal_cmd(), .ap_done());
    cpr_dram cpr_dram_b_inst (.clk(clk), .rst_b(rst_b), .link(link_b.dram),
        .pattern_mode(b_mode), .pattern_loc(b_loc), .illegal_cmd(b_ill), .ap_done(b_ap));
    cpr_link_sva cpr_link_sva_inst (.clk(clk), .rst_b(rst_b), .reset_b(link_a.reset_b),
        .cs_n(link_a.cs_n), .ras_n(link_a.ras_n), .cas_n(link_a.cas_n), .we_n(link_a.we_n),
        .ba(link_a.ba), .addr(link_a.addr), .dram_dq_o(link_a.dram_dq_o),
        .dram_dq_oe(link_a.dram_dq_oe));
    // Pulses are caught off the rising edge so that no sampling race arises.
    always @(negedge clk) begin
        if (b_ap === 1'h1) ap_seen = 1'h1;
        if (b_ill === 1'h1) ill_seen = 1'h1;
    end
    task close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task cmd(input logic [2:0] rcw, input logic [2:0] b, input logic [15:0] a);
        @(negedge clk);
        link_b.cs_n = 1'h0;
        {link_b.ras_n, link_b.cas_n, link_b.we_n} = rcw;
        link_b.ba = b;
        link_b.addr = a;
        @(negedge clk);
        link_b.cs_n = 1'h1;
        {link_b.ras_n, link_b.cas_n, link_b.we_n} = cpr_pkg::CMD_NOP;
    endtask
    function automatic logic [63:0] pat64(input int first);
        logic [63:0] v;
        for (int k = 0; k < 8; k++) v[8*k+:8] = {8{cpr_pkg::PAT_CAL[(first + k) % 8]}};
        return v;
    endfunction
    // Banks are always 7 here, so bank bits must make no difference.
    task rd_b(input logic [15:0] a, input int n, input logic [63:0] exp);
        int lat;
        cmd(cpr_pkg::CMD_RD, 3'h7, a);
        lat = 1;
        while (link_b.dram_dq_oe !== 1'h1 && lat < 20) begin
            @(negedge clk);
            lat++;
        end
        chk("read latency", 8'(cpr_pkg::READ_LAT), 8'(lat));
        if (lat >= 20) begin
            close_out();
        end
        for (int k = 0; k < n; k++) begin
            chk("read beat", exp[8*k+:8], link_b.dq);
            @(negedge clk);
        end
        chk("burst end", 8'h0, 8'(link_b.dram_dq_oe));
    endtask
    task wr_b(input logic [15:0] a, input logic [63:0] d);
        cmd(cpr_pkg::CMD_WR, 3'h7, a);
        idle(3);
        link_b.ctl_dq_oe = 1'h1;
        for (int k = 0; k < 8; k++) begin
            link_b.ctl_dq_o = d[8*k+:8];
            @(negedge clk);
        end
        link_b.ctl_dq_oe = 1'h0;
    endtask
    task run(input logic chop, input logic up, input logic [7:0] exp);
        int i;
        int beats;
        @(negedge clk);
        start = 1'h1;
        use_chop = chop;
        upper_half = up;
        @(negedge clk);
        start = 1'h0;
        i = 0;
        beats = 0;
        while (done !== 1'h1 && i < 400) begin
            if (link_a.dram_dq_oe === 1'h1) beats++;
            @(negedge clk);
            i++;
        end
        if (i == 400) begin
            err_count++;
            close_out();
        end
        chk("pass", 8'h1, 8'(pass));
        chk("pattern", exp, pattern);
        chk("link beats", chop ? 8'h4 : 8'h8, 8'(beats));
    endtask
    initial begin
        link_b.reset_b = 1'h0;
        link_b.cs_n = 1'h1;
        {link_b.ras_n, link_b.cas_n, link_b.we_n} = cpr_pkg::CMD_NOP;
        link_b.ba = 3'h0;
        link_b.addr = 16'h0000;
        link_b.ctl_dq_o = 8'h00;
        link_b.ctl_dq_oe = 1'h0;
        ap_seen = 1'h0;
        ill_seen = 1'h0;
        idle(4);
        rst_b = 1'h1;
        link_b.reset_b = 1'h1;
        dll_locked = 1'h0;
        start = 1'h1;
        idle(3);
        chk("busy", 8'h0, 8'(busy));
        start = 1'h0;
        dll_locked = 1'h1;
        run(1'h0, 1'h0, cpr_pkg::PAT_CAL);
        run(1'h1, 1'h0, cpr_pkg::PAT_CAL & 8'h0f);
        run(1'h1, 1'h1, cpr_pkg::PAT_CAL & 8'hf0);
        idle(2);
        wr_b(16'h0008, arr);
        idle(8);
        cmd(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR3, 16'h0001);
        idle(12);
        chk("location", 8'h1, 8'(b_loc));
        rd_b(16'h0008, 8, arr);
        cmd(cpr_pkg::CMD_PRE, 3'h0, 16'h0400);
        idle(2);
        cmd(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR3, 16'h0004);
        idle(1);
        chk("mode on", 8'h1, 8'(b_mode));
        idle(12);
        rd_b(16'h27f8, 8, pat64(0));
        idle(4);
        chk("autoprecharge", 8'h0, 8'(ap_seen));
        for (int t = 0; t < 4; t++) begin
            cmd(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR0, {14'h0, tb_bl[t]});
            idle(12);
            rd_b(tb_a[t], tb_n[t], pat64(tb_f[t]));
        end
        cmd(cpr_pkg::CMD_WR, 3'h7, 16'h0008);
        idle(2);
        chk("refused write", 8'h1, 8'(ill_seen));
        cmd(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR3, 16'h0000);
        idle(12);
        chk("mode off", 8'h0, 8'(b_mode));
        rd_b(16'h0008, 4, arr);
        rd_b(16'h0408, 4, arr);
        idle(2);
        chk("array autoprecharge", 8'h1, 8'(ap_seen));
        cmd(cpr_pkg::CMD_MRS, cpr_pkg::BA_MR3, 16'h0004);
        idle(1);
        link_b.reset_b = 1'h0;
        idle(2);
        chk("mode after reset", 8'h0, 8'(b_mode));
        link_b.reset_b = 1'h1;
        close_out();
    end
endmodule
